// ---- rtl/ees_params.svh ----
// Constants of the EEPROM erase and write sequencer.
`ifndef EES_PARAMS_SVH
`define EES_PARAMS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EES_OFS_CTRL 2'h0
`define EES_OFS_ADDR_LO 2'h1
`define EES_OFS_ADDR_HI 2'h2
`define EES_OFS_DATA 2'h3
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define EES_BIT_PE 1
`define EES_BIT_MPE 2
`define EES_BIT_MODE_LO 4
`define EES_BIT_MODE_HI 5
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EES_RST_BYTE 8'h00
`define EES_RST_MODE 2'h0
// ----------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------
`define EES_UNLOCK_CYCLES 3'h4
`define EES_STALL_CYCLES 2'h2
`endif

// ---- rtl/ees_pkg.sv ----
// Types of the EEPROM erase and write sequencer.
package ees_pkg;
   typedef enum logic [1:0] {
      EES_MODE_ERASE_WRITE = 2'h0,
      EES_MODE_ERASE_ONLY = 2'h1,
      EES_MODE_WRITE_ONLY = 2'h2,
      EES_MODE_RESERVED = 2'h3
   } ees_mode_t;
   typedef enum logic {
      EES_IDLE = 1'b0,
      EES_RUN = 1'b1
   } ees_state_t;
   typedef struct packed {
      ees_mode_t op;
      logic [15:0] addr;
      logic [7:0] data;
   } ees_arr_req_t;
endpackage : ees_pkg

// ---- rtl/ees_sequencer.sv ----
// EEPROM erase and write sequencer with timed unlock and CPU stall.
// Summary of operation
// [RULE_01] An operation starts only when program enable is written within four cycles after master enable.
// [RULE_02] A launch stalls the processor for two clock cycles.
// [RULE_03] Program enable reads set as busy until the array reports completion.
// [RULE_04] While busy, no further launch and no change of mode, address or data is accepted.
// [RULE_05] Software sets the mode bits before launch and the erase setting selects erase only.
// [RULE_06] The mode bits select erase and write, erase only or write only.
// [RULE_07] Software polls program enable until clear before starting.
// [RULE_08] Software waits for flash self-programming to end when a boot loader may run.
// [RULE_09] The operation targets the location held in the high and low address registers.
// [RULE_10] A write programs the data register content into the addressed location.
// [RULE_11] Software erases a location before writing it.
// [RULE_12] The interrupt-disable instruction blocks interrupts in its own cycle.
// [RULE_13] Software disables interrupts around the unlock writes.
// [RULE_14] Master enable clears itself when the four-cycle window expires.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ees_params.svh"
module ees_sequencer
   import ees_pkg::*;
#(
   parameter int ADDR_W = 9
) (
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   input wire logic [1:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   output logic ARR_START_O,
   output ees_arr_req_t ARR_REQ_O,
   input wire logic ARR_DONE_I,
   output logic CPU_STALL_O,
   input wire logic IRQ_PEND_I,
   input wire logic IRQ_GLOBAL_EN_I,
   input wire logic CLI_EXEC_I,
   output logic IRQ_TAKE_O
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   ees_state_t state_q, state_d;
   ees_mode_t mode_q, mode_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic [2:0] unlock_q, unlock_d;
   logic [1:0] stall_q, stall_d;
   logic start_q, start_d;
   ees_arr_req_t req_q, req_d;
   logic [7:0] rdata_q, rdata_d;
   logic [15:0] addr_ext;
   logic wr_ctrl, mpe_q, launch;

   assign addr_ext = 16'(addr_q);
   assign wr_ctrl = REG_WR_I && (REG_ADDR_I == `EES_OFS_CTRL);
   assign mpe_q = (unlock_q != 3'h0);
   assign launch = wr_ctrl && REG_WDATA_I[`EES_BIT_PE] && mpe_q && (state_q == EES_IDLE)
      && (mode_q != EES_MODE_RESERVED); // RULE_01

   always_comb begin
      state_d = state_q;
      mode_d = mode_q;
      addr_d = addr_q;
      data_d = data_q;
      unlock_d = unlock_q;
      stall_d = stall_q;
      start_d = 1'b0;
      req_d = req_q;
      rdata_d = 8'h00;
      if (unlock_q != 3'h0) begin
         unlock_d = unlock_q - 3'h1; // RULE_14
      end
      if (stall_q != 2'h0) begin
         stall_d = stall_q - 2'h1;
      end
      if (REG_WR_I && (state_q == EES_IDLE)) begin // RULE_04
         case (REG_ADDR_I)
            `EES_OFS_CTRL: begin
               mode_d = ees_mode_t'(REG_WDATA_I[`EES_BIT_MODE_HI:`EES_BIT_MODE_LO]); // RULE_05
               if (REG_WDATA_I[`EES_BIT_MPE]) begin
                  unlock_d = `EES_UNLOCK_CYCLES; // RULE_01
               end
            end
            `EES_OFS_ADDR_LO: begin
               addr_d = ADDR_W'({addr_ext[15:8], REG_WDATA_I});
            end
            `EES_OFS_ADDR_HI: begin
               addr_d = ADDR_W'({REG_WDATA_I, addr_ext[7:0]});
            end
            `EES_OFS_DATA: begin
               data_d = REG_WDATA_I;
            end
            default: begin
               data_d = data_q;
            end
         endcase
      end
      case (state_q)
         EES_IDLE: begin
            if (launch) begin
               state_d = EES_RUN; // RULE_03
               start_d = 1'b1;
               stall_d = `EES_STALL_CYCLES; // RULE_02
               unlock_d = 3'h0;
               req_d.op = mode_q; // RULE_06
               req_d.addr = addr_ext; // RULE_09
               req_d.data = data_q; // RULE_10
            end
         end
         EES_RUN: begin
            if (ARR_DONE_I && !start_q) begin
               state_d = EES_IDLE; // RULE_03
            end
         end
         default: begin
            state_d = EES_IDLE;
         end
      endcase
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            `EES_OFS_CTRL: begin
               rdata_d[`EES_BIT_PE] = (state_q == EES_RUN); // RULE_03
               rdata_d[`EES_BIT_MPE] = mpe_q;
               rdata_d[`EES_BIT_MODE_HI:`EES_BIT_MODE_LO] = mode_q;
            end
            `EES_OFS_ADDR_LO: begin
               rdata_d = addr_ext[7:0];
            end
            `EES_OFS_ADDR_HI: begin
               rdata_d = addr_ext[15:8];
            end
            default: begin
               rdata_d = data_q;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         state_q <= EES_IDLE;
         mode_q <= ees_mode_t'(`EES_RST_MODE);
         addr_q <= '0;
         data_q <= `EES_RST_BYTE;
         unlock_q <= 3'h0;
         stall_q <= 2'h0;
         start_q <= 1'b0;
         req_q <= '0;
         rdata_q <= `EES_RST_BYTE;
      end else begin
         state_q <= state_d;
         mode_q <= mode_d;
         addr_q <= addr_d;
         data_q <= data_d;
         unlock_q <= unlock_d;
         stall_q <= stall_d;
         start_q <= start_d;
         req_q <= req_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_RDATA_O = rdata_q;
   assign ARR_START_O = start_q;
   assign ARR_REQ_O = req_q;
   assign CPU_STALL_O = (stall_q != 2'h0); // RULE_02
   assign IRQ_TAKE_O = IRQ_PEND_I && IRQ_GLOBAL_EN_I && !CLI_EXEC_I; // RULE_12

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RESET_I);

   sequence s_launch;
      launch;
   endsequence

   sequence s_stall_two;
      CPU_STALL_O [*2] ##1 !CPU_STALL_O;
   endsequence

   unlock_window_a: assert property ( // RULE_01
      (wr_ctrl && REG_WDATA_I[`EES_BIT_PE] && state_q == EES_IDLE && mode_q != EES_MODE_RESERVED
       && $past(wr_ctrl && REG_WDATA_I[`EES_BIT_MPE], 5) && !$past(wr_ctrl, 4) && !$past(wr_ctrl, 3)
       && !$past(wr_ctrl, 2) && !$past(wr_ctrl, 1)) |=> !ARR_START_O)
      else $error("late program enable started an operation");
   unlock_start_a: assert property ( // RULE_01
      (wr_ctrl && REG_WDATA_I[`EES_BIT_MPE] && state_q == EES_IDLE) ##1 (!REG_WR_I) [*3]
      ##1 (wr_ctrl && REG_WDATA_I[`EES_BIT_PE] && mode_q != EES_MODE_RESERVED) |=> ARR_START_O)
      else $error("program enable inside window did not start");
   cpu_stall_a: assert property (s_launch |=> s_stall_two) // RULE_02
      else $error("stall is not two cycles");
   busy_hold_a: assert property ( // RULE_03
      (state_q == EES_RUN && !ARR_DONE_I) |=> state_q == EES_RUN)
      else $error("busy dropped before completion");
   no_relaunch_a: assert property ( // RULE_04
      state_q == EES_RUN |=> !ARR_START_O)
      else $error("operation accepted while busy");
   busy_freeze_a: assert property ( // RULE_04
      state_q == EES_RUN |=> $stable(mode_q) && $stable(addr_q) && $stable(data_q))
      else $error("settings changed while busy");
   mode_pass_a: assert property ( // RULE_05
      s_launch |=> ARR_REQ_O.op == $past(mode_q))
      else $error("wrong operation kind sent");
   addr_pass_a: assert property ( // RULE_09
      s_launch |=> ARR_REQ_O.addr == 16'($past(addr_q)) && ARR_REQ_O.data == $past(data_q)) // RULE_10
      else $error("wrong location or data sent");
   irq_block_a: assert property ( // RULE_12
      CLI_EXEC_I |-> !IRQ_TAKE_O)
      else $error("interrupt taken with disable instruction");
   mpe_expire_a: assert property ( // RULE_14
      (mpe_q && !REG_WR_I) [*4] |=> !mpe_q)
      else $error("master enable outlived its window");
endmodule : ees_sequencer
`default_nettype wire

// ---- verif/ees_array_model.sv ----
// Behavioural model of the EEPROM array.
`timescale 1ns/10ps
`default_nettype none
module ees_array_model (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [7:0] lat_i,
   output logic done_o
);
   int cnt = 0;
   initial done_o = 1'b0;
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (start_i === 1'b1) begin
         cnt = lat_i;
      end else if (cnt > 1) begin
         cnt = cnt - 1;
      end else if (cnt == 1) begin
         cnt = 0;
         done_o <= 1'b1;
      end
   end
endmodule : ees_array_model
`default_nettype wire

// ---- verif/ees_sequencer_tb_top.sv ----
// Self-checking testbench of the EEPROM erase and write sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "ees_params.svh"
module ees_sequencer_tb_top;
   import ees_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, pend = 0, gen = 0, cli = 0;
   logic done, start, stall, take;
   logic [1:0] addr = 0;
   logic [7:0] wd = 0, rdata, v, lat = 8'h01;
   logic hold_irq = 0;
   logic [15:0] ta = 0;
   ees_arr_req_t req;
   int n_errors = 0, check_count = 0, n_start = 0, exp_start = 0;
   always #20 clk = ~clk;
   ees_sequencer DUT (.CORE_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ARR_START_O(start),
      .ARR_REQ_O(req), .ARR_DONE_I(done), .CPU_STALL_O(stall), .IRQ_PEND_I(pend),
      .IRQ_GLOBAL_EN_I(gen), .CLI_EXEC_I(cli), .IRQ_TAKE_O(take));
   ees_array_model ARR (.clk_i(clk), .start_i(start), .lat_i(lat), .done_o(done));
   task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
   endtask : wreg
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic rreg(input logic [1:0] a);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask : rreg
   task automatic launch(input logic [1:0] m, input int g, input logic [15:0] a,
         input logic [7:0] d);
      logic ok;
      logic [25:0] exp;
      ok = (m != 2'h3) && (g < 4);
      exp = {m, 7'h00, a[8:0], d};
      rreg(`EES_OFS_CTRL);
      while (v[1] !== 1'b0) rreg(`EES_OFS_CTRL);
      repeat ($urandom % 3) @(posedge clk);
      wreg(`EES_OFS_ADDR_LO, a[7:0]);
      wreg(`EES_OFS_ADDR_HI, a[15:8]);
      wreg(`EES_OFS_DATA, d);
      hold_irq <= 1'b1;
      wreg(`EES_OFS_CTRL, {2'h0, m, 4'h4});
      if (g > 0) idle(g);
      wreg(`EES_OFS_CTRL, {2'h0, m, 4'h2});
      hold_irq <= 1'b0;
      idle(0);
      @(negedge clk);
      chk(start, ok, "start");
      chk(stall, ok, "stall");
      if (ok) begin
         exp_start++;
         chk(req, exp, "request");
         @(negedge clk);
         chk(stall, 1, "stall second");
         @(negedge clk);
         chk(stall, 0, "stall end");
         @(posedge clk);
         if (lat > 11) begin
            rreg(`EES_OFS_CTRL);
            chk(v[1], 1, "busy");
            wreg(`EES_OFS_DATA, ~d);
            wreg(`EES_OFS_CTRL, 8'h04);
            wreg(`EES_OFS_CTRL, 8'h02);
            idle(1);
            @(negedge clk);
            chk(req, exp, "held");
            @(posedge clk);
         end
         v = 8'h02;
         for (int k = 0; k < 60 && v[1] === 1'b1; k++) rreg(`EES_OFS_CTRL);
      end else begin
         @(posedge clk);
         rreg(`EES_OFS_CTRL);
      end
      chk(v[2:1], 0, "idle");
      rreg(`EES_OFS_DATA);
      chk(v, d, "data kept");
   endtask : launch
   always @(posedge clk) begin
      {pend, gen, cli} <= 3'($urandom) & {1'b1, ~hold_irq, 1'b1};
      if (start === 1'b1) n_start++;
   end
   always @(negedge clk) begin
      if (!rst) chk(take, pend & gen & ~cli, "irq");
   end
   initial begin
      v = 8'($urandom(32'hA54E4A6C));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 4; a++) begin
         rreg(2'(a));
         chk(v, `EES_RST_BYTE, "reset");
      end
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         lat <= (i < 3) ? 8'h01 : 8'(12 + $urandom % 30);
         if (i % 4 != 2) ta = 16'($urandom);
         launch((i == 7) ? 2'h1 : 2'(i % 4), (i == 7) ? 4 : (i + 3 + i / 4) % 4, ta,
            8'($urandom));
         $display("test launch %0d done", i);
      end
      chk(n_start, exp_start, "starts");
      stop_test();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      $display("wrong value at %0t: timeout", $time);
      stop_test();
   end
endmodule : ees_sequencer_tb_top
`default_nettype wire
